// ==== verilog/tls_pkg.sv ====
// constants for the torque limit and status filter block
// assumes a single system clock and a parameter write port from the drive
`default_nettype none
package tls_pkg;
    // parameter port indices
    localparam logic [3:0] IDX_SWITCH_SEL  = 4'h0;
    localparam logic [3:0] IDX_FWD_LIM2    = 4'h1;
    localparam logic [3:0] IDX_REV_LIM2    = 4'h2;
    localparam logic [3:0] IDX_FE_FILT     = 4'h3;
    localparam logic [3:0] IDX_INP_FILT    = 4'h4;
    localparam logic [3:0] IDX_SPD_FILT    = 4'h5;
    localparam logic [3:0] IDX_MAXTQ_SEL   = 4'h6;
    localparam logic [3:0] IDX_POS_OBJ2    = 4'h7;
    localparam logic [3:0] IDX_NEG_OBJ2    = 4'h8;
    localparam logic [3:0] IDX_MAX_TORQUE  = 4'h9;
    localparam logic [3:0] IDX_STATUS      = 4'ha;
    // reset values
    localparam logic [31:0] RST_SWITCH_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_MAXTQ_SEL  = 32'h0000_0010;
    localparam logic [15:0] RST_LIM2       = 16'h2710;
    localparam logic [15:0] RST_FILT       = 16'h0000;
    // limits in 0.1 % of rated torque, 1000.0 % top
    localparam logic [15:0] LIM_MAX        = 16'h2710;
    // field positions
    localparam int SWITCH_LSB  = 0;
    localparam int MAXTQ_LSB   = 4;
    localparam logic [3:0] FIELD_ON = 4'h1;
    localparam int CW_FWD_REQ  = 11;
    localparam int CW_REV_REQ  = 12;
    localparam int SW_TARGET   = 10;
    localparam int SW_FOLLOW   = 13;
    // disable codes
    localparam logic [31:0] FE_LEVEL_OFF = 32'h0fff_ffff;
    localparam logic [31:0] INP_ALWAYS   = 32'hffff_ffff;
    // operation mode codes
    localparam logic [7:0] MODE_PP  = 8'h01;
    localparam logic [7:0] MODE_PV  = 8'h03;
    localparam logic [7:0] MODE_CSP = 8'h08;
    localparam logic [7:0] MODE_JG  = 8'hfd;
    localparam logic [7:0] MODE_PT  = 8'hfe;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FILT_UNIT_NS  = 1000000;
    localparam int CYC_PER_MS    = FILT_UNIT_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== verilog/tls_core.sv ====
// torque limit selection and statusword output filters for one axis
// assumes all inputs come from logic on clk_sys; limits in 0.1 % units
// Overview of operation
// - switching enable held, reset disabled
// - controlword bits 11/12 request secondary limits
// - enabled plus request selects secondary limit
// - secondary limits 0.0..1000.0 %, default 1000.0
// - zero limit gives no torque
// - clamp effective limit to motor maximum
// - forward governs ccw power, cw regen
// - object mapping swaps with direction, polarity
// - following error bit after filter time
// - following error only in position modes
// - level 0x0fff_ffff disables following error
// - target reached after in-position filter time
// - all-ones in-position range forces target reached
// - in-position filter only pp, pt, jog
// - velocity reached after speed filter time
// - speed filter only in profile velocity
// - filter times in ms, 0..65535
// - max torque limit 1 select, default on
// - limit 1 off reports motor maximum
`timescale 1ns/1ps
`default_nettype none
module tls_core #(
    parameter int CYC_MS = tls_pkg::CYC_PER_MS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        param_wr_en,
    input  wire logic [3:0]  param_wr_idx,
    input  wire logic [31:0] param_wdata,
    input  wire logic [3:0]  param_rd_idx,
    output logic      [31:0] param_rdata,
    input  wire logic [15:0] control_word,
    input  wire logic [7:0]  op_mode,
    input  wire logic [15:0] fwd_torque_limit_primary,
    input  wire logic [15:0] rev_torque_limit_primary,
    input  wire logic [15:0] max_torque_limit_one,
    input  wire logic [15:0] motor_max_torque,
    input  wire logic        travel_direction_select,
    input  wire logic        torque_polarity_reflect_select,
    input  wire logic [31:0] droop_count,
    input  wire logic [31:0] following_error_level,
    input  wire logic [31:0] position_error,
    input  wire logic [31:0] in_position_range,
    input  wire logic [31:0] speed_error,
    input  wire logic [31:0] speed_reached_range,
    output logic      [15:0] fwd_torque_limit,
    output logic      [15:0] rev_torque_limit,
    output logic      [15:0] max_torque_report,
    output logic             status_target_reached,
    output logic             status_following_error
);
    // elaboration-time guard: the prescaler needs at least one cycle per ms
    if (CYC_MS < 1) begin
        $error("CYC_MS must be at least one");
    end

    function automatic logic [15:0] min16(input logic [15:0] a,
                                          input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction

    // count stops one past the setting, so 16 bit times never wrap
    function automatic logic [16:0] filt_next(input logic        cond,
                                              input logic        tick,
                                              input logic [16:0] cnt,
                                              input logic [15:0] tm);
        if (!cond) begin
            filt_next = 17'h0_0000;
        end else if (tick && cnt <= {1'b0, tm}) begin
            filt_next = cnt + 17'h0_0001;
        end else begin
            filt_next = cnt;
        end
    endfunction

    logic [31:0] switch_sel_q, switch_sel_d;
    logic [31:0] maxtq_sel_q, maxtq_sel_d;
    logic [15:0] fwd_lim2_q, fwd_lim2_d, rev_lim2_q, rev_lim2_d;
    logic [15:0] fe_time_q, fe_time_d, inp_time_q, inp_time_d;
    logic [15:0] spd_time_q, spd_time_d;
    logic        switch_en, maxtq_en, obj_swap;

    // parameter store
    always_comb begin
        switch_sel_d = switch_sel_q;
        maxtq_sel_d  = maxtq_sel_q;
        fwd_lim2_d   = fwd_lim2_q;
        rev_lim2_d   = rev_lim2_q;
        fe_time_d    = fe_time_q;
        inp_time_d   = inp_time_q;
        spd_time_d   = spd_time_q;
        if (param_wr_en) begin
            if (param_wr_idx == tls_pkg::IDX_SWITCH_SEL) begin
                switch_sel_d = param_wdata;
            end else if (param_wr_idx == tls_pkg::IDX_MAXTQ_SEL) begin
                maxtq_sel_d = param_wdata;
            end else if (param_wr_idx == tls_pkg::IDX_FWD_LIM2) begin
                // out of range writes are dropped
                if (param_wdata <= {16'h0000, tls_pkg::LIM_MAX}) begin
                    fwd_lim2_d = param_wdata[15:0];
                end
            end else if (param_wr_idx == tls_pkg::IDX_REV_LIM2) begin
                if (param_wdata <= {16'h0000, tls_pkg::LIM_MAX}) begin
                    rev_lim2_d = param_wdata[15:0];
                end
            end else if (param_wr_idx == tls_pkg::IDX_FE_FILT) begin
                // last write wins, cyclic or tool alike
                fe_time_d = param_wdata[15:0];
            end else if (param_wr_idx == tls_pkg::IDX_INP_FILT) begin
                inp_time_d = param_wdata[15:0];
            end else if (param_wr_idx == tls_pkg::IDX_SPD_FILT) begin
                spd_time_d = param_wdata[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            switch_sel_q <= tls_pkg::RST_SWITCH_SEL;
            maxtq_sel_q  <= tls_pkg::RST_MAXTQ_SEL;
            fwd_lim2_q   <= tls_pkg::RST_LIM2;
            rev_lim2_q   <= tls_pkg::RST_LIM2;
            fe_time_q    <= tls_pkg::RST_FILT;
            inp_time_q   <= tls_pkg::RST_FILT;
            spd_time_q   <= tls_pkg::RST_FILT;
        end else begin
            switch_sel_q <= switch_sel_d;
            maxtq_sel_q  <= maxtq_sel_d;
            fwd_lim2_q   <= fwd_lim2_d;
            rev_lim2_q   <= rev_lim2_d;
            fe_time_q    <= fe_time_d;
            inp_time_q   <= inp_time_d;
            spd_time_q   <= spd_time_d;
        end
    end

    assign switch_en = switch_sel_q[tls_pkg::SWITCH_LSB +: 4]
                       == tls_pkg::FIELD_ON;
    assign maxtq_en  = maxtq_sel_q[tls_pkg::MAXTQ_LSB +: 4]
                       == tls_pkg::FIELD_ON;
    assign obj_swap  = travel_direction_select
                       ^ torque_polarity_reflect_select;

    // limit selection
    logic [15:0] fwd_lim_d, rev_lim_d, maxrep_d, fwd_sel, rev_sel;
    logic [31:0] rdata_d;

    always_comb begin
        fwd_sel = fwd_torque_limit_primary;
        rev_sel = rev_torque_limit_primary;
        if (switch_en && control_word[tls_pkg::CW_FWD_REQ]) begin
            fwd_sel = fwd_lim2_q;
        end
        if (switch_en && control_word[tls_pkg::CW_REV_REQ]) begin
            rev_sel = rev_lim2_q;
        end
        // forward caps ccw power and cw regen, reverse the rest
        fwd_lim_d = min16(fwd_sel, motor_max_torque);
        rev_lim_d = min16(rev_sel, motor_max_torque);
        if (maxtq_en) begin
            fwd_lim_d = min16(fwd_lim_d, max_torque_limit_one);
            rev_lim_d = min16(rev_lim_d, max_torque_limit_one);
            maxrep_d  = max_torque_limit_one;
        end else begin
            maxrep_d  = motor_max_torque;
        end
    end

    // filters
    logic [$clog2(CYC_MS+1)-1:0] pre_q, pre_d;
    logic        ms_tick;
    logic        fe_cond, inp_cond, spd_cond, pos_mode, inp_mode;
    logic [16:0] fe_cnt_q, fe_cnt_d, inp_cnt_q, inp_cnt_d;
    logic [16:0] spd_cnt_q, spd_cnt_d;
    logic        fe_d, tr_d;

    assign ms_tick = (pre_q == ($bits(pre_q))'(CYC_MS - 1));

    always_comb begin
        pre_d = ms_tick ? '0 : pre_q + 1'b1;
        pos_mode = (op_mode == tls_pkg::MODE_CSP)
                   || (op_mode == tls_pkg::MODE_PP)
                   || (op_mode == tls_pkg::MODE_PT)
                   || (op_mode == tls_pkg::MODE_JG);
        inp_mode = (op_mode == tls_pkg::MODE_PP)
                   || (op_mode == tls_pkg::MODE_PT)
                   || (op_mode == tls_pkg::MODE_JG);
        fe_cond  = pos_mode
                   && (following_error_level != tls_pkg::FE_LEVEL_OFF)
                   && (droop_count >= following_error_level);
        inp_cond = inp_mode && (position_error <= in_position_range);
        spd_cond = (op_mode == tls_pkg::MODE_PV)
                   && (speed_error <= speed_reached_range);
        fe_cnt_d  = filt_next(fe_cond, ms_tick, fe_cnt_q, fe_time_q);
        inp_cnt_d = filt_next(inp_cond, ms_tick, inp_cnt_q, inp_time_q);
        spd_cnt_d = filt_next(spd_cond, ms_tick, spd_cnt_q, spd_time_q);
        // bits drop with the condition, counts restart
        fe_d = fe_cond && (fe_cnt_q >= {1'b0, fe_time_q});
        tr_d = (inp_cond && (inp_cnt_q >= {1'b0, inp_time_q}))
               || (spd_cond && (spd_cnt_q >= {1'b0, spd_time_q}))
               || (in_position_range == tls_pkg::INP_ALWAYS);
    end

    // object reads; only indices 7 and 8 follow the direction/polarity swap
    always_comb begin
        if (param_rd_idx == tls_pkg::IDX_SWITCH_SEL) begin
            rdata_d = switch_sel_q;
        end else if (param_rd_idx == tls_pkg::IDX_FWD_LIM2) begin
            rdata_d = {16'h0000, fwd_lim2_q};
        end else if (param_rd_idx == tls_pkg::IDX_REV_LIM2) begin
            rdata_d = {16'h0000, rev_lim2_q};
        end else if (param_rd_idx == tls_pkg::IDX_FE_FILT) begin
            rdata_d = {16'h0000, fe_time_q};
        end else if (param_rd_idx == tls_pkg::IDX_INP_FILT) begin
            rdata_d = {16'h0000, inp_time_q};
        end else if (param_rd_idx == tls_pkg::IDX_SPD_FILT) begin
            rdata_d = {16'h0000, spd_time_q};
        end else if (param_rd_idx == tls_pkg::IDX_MAXTQ_SEL) begin
            rdata_d = maxtq_sel_q;
        end else if (param_rd_idx == tls_pkg::IDX_POS_OBJ2) begin
            rdata_d = {16'h0000, obj_swap ? rev_lim2_q : fwd_lim2_q};
        end else if (param_rd_idx == tls_pkg::IDX_NEG_OBJ2) begin
            rdata_d = {16'h0000, obj_swap ? fwd_lim2_q : rev_lim2_q};
        end else if (param_rd_idx == tls_pkg::IDX_MAX_TORQUE) begin
            rdata_d = {16'h0000, max_torque_report};
        end else if (param_rd_idx == tls_pkg::IDX_STATUS) begin
            rdata_d = 32'h0000_0000;
            rdata_d[tls_pkg::SW_TARGET] = status_target_reached;
            rdata_d[tls_pkg::SW_FOLLOW] = status_following_error;
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pre_q                  <= '0;
            fe_cnt_q               <= 17'h0_0000;
            inp_cnt_q              <= 17'h0_0000;
            spd_cnt_q              <= 17'h0_0000;
            status_following_error <= 1'b0;
            status_target_reached  <= 1'b0;
            fwd_torque_limit       <= 16'h0000;
            rev_torque_limit       <= 16'h0000;
            max_torque_report      <= 16'h0000;
            param_rdata            <= 32'h0000_0000;
        end else begin
            pre_q                  <= pre_d;
            fe_cnt_q               <= fe_cnt_d;
            inp_cnt_q              <= inp_cnt_d;
            spd_cnt_q              <= spd_cnt_d;
            status_following_error <= fe_d;
            status_target_reached  <= tr_d;
            fwd_torque_limit       <= fwd_lim_d;
            rev_torque_limit       <= rev_lim_d;
            max_torque_report      <= maxrep_d;
            param_rdata            <= rdata_d;
        end
    end

    // checks
    property p_switch_reset;
        @(posedge clk_sys) $rose(rst_n) |-> !switch_en;
    endproperty
    a_switch_reset: assert property (p_switch_reset)
        else $error("switch enable not cleared by reset");

    property p_primary_when_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (!switch_en && !maxtq_en) |=> fwd_torque_limit
        == min16($past(fwd_torque_limit_primary), $past(motor_max_torque));
    endproperty
    a_primary_when_off: assert property (p_primary_when_off)
        else $error("primary forward limit not applied");

    property p_sel_fwd;
        @(posedge clk_sys) disable iff (!rst_n)
        (switch_en && control_word[tls_pkg::CW_FWD_REQ] && !maxtq_en)
        |=> fwd_torque_limit == min16($past(fwd_lim2_q), $past(motor_max_torque));
    endproperty
    a_sel_fwd: assert property (p_sel_fwd)
        else $error("secondary forward limit not applied");

    property p_sel_rev_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (!switch_en && !maxtq_en) |=> rev_torque_limit
        == min16($past(rev_torque_limit_primary), $past(motor_max_torque));
    endproperty
    a_sel_rev_off: assert property (p_sel_rev_off)
        else $error("primary reverse limit not applied");

    property p_clamp;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 fwd_torque_limit <= $past(motor_max_torque)
        && rev_torque_limit <= $past(motor_max_torque);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("limit above motor maximum");

    property p_fe_mode;
        @(posedge clk_sys) disable iff (!rst_n)
        !pos_mode |=> !status_following_error;
    endproperty
    a_fe_mode: assert property (p_fe_mode)
        else $error("following error outside position modes");

    property p_fe_off;
        @(posedge clk_sys) disable iff (!rst_n)
        following_error_level == tls_pkg::FE_LEVEL_OFF
        |=> !status_following_error;
    endproperty
    a_fe_off: assert property (p_fe_off)
        else $error("following error with level disabled");

    property p_inp_always;
        @(posedge clk_sys) disable iff (!rst_n)
        in_position_range == tls_pkg::INP_ALWAYS |=> status_target_reached;
    endproperty
    a_inp_always: assert property (p_inp_always)
        else $error("target reached not forced");

    property p_fe_drop;
        @(posedge clk_sys) disable iff (!rst_n)
        !fe_cond |=> fe_cnt_q == 17'h0_0000 && !status_following_error;
    endproperty
    a_fe_drop: assert property (p_fe_drop)
        else $error("following error timer not restarted");

    property p_fe_zero_time;
        @(posedge clk_sys) disable iff (!rst_n)
        (fe_cond && fe_time_q == 16'h0000) |=> status_following_error;
    endproperty
    a_fe_zero_time: assert property (p_fe_zero_time)
        else $error("zero filter time did not set bit at once");

    property p_maxrep;
        @(posedge clk_sys) disable iff (!rst_n)
        !maxtq_en |=> max_torque_report == $past(motor_max_torque);
    endproperty
    a_maxrep: assert property (p_maxrep)
        else $error("max torque not reported as motor maximum");
endmodule
`default_nettype wire

// ==== tb/tls_ctrl_model.sv ====
// network controller model: forms the controlword, collects the statusword
// assumes requests and mode change away from the rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module tls_ctrl_model (
    input  wire logic        clk_sys,
    input  wire logic        fwd_req,
    input  wire logic        rev_req,
    input  wire logic [7:0]  mode,
    input  wire logic        tgt_bit,
    input  wire logic        fe_bit,
    output logic      [15:0] control_word,
    output logic      [7:0]  op_mode,
    output logic      [15:0] status_word
);
    // other controlword bits stay low so only the two requests move
    assign control_word = {3'h0, rev_req, fwd_req, 11'h000};
    assign op_mode = mode;
    // captured on the rising edge like a cyclic input image, one driver only
    always @(posedge clk_sys) begin
        status_word <= {2'h0, fe_bit, 2'h0, tgt_bit, 10'h000};
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the torque limit and status filter block
// assumes the controller model drives controlword and mode
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        wen = 1'b0;
    logic [3:0]  widx = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  ridx = 4'h0;
    logic [31:0] rdat;
    logic        freq = 1'b0;
    logic        rreq = 1'b0;
    logic [7:0]  mode = 8'h00;
    logic [15:0] fprim = 16'h0100;
    logic [15:0] rprim = 16'h0200;
    logic [15:0] lim1 = 16'h2710;
    logic [15:0] mmax = 16'h1000;
    logic        dir = 1'b0;
    logic        pol = 1'b0;
    logic [31:0] droop = 32'h0;
    logic [31:0] fe_lvl = 32'h64;
    logic [31:0] perr = 32'h14;
    logic [31:0] prng = 32'ha;
    logic [31:0] serr = 32'h14;
    logic [31:0] srng = 32'ha;
    logic [15:0] cw;
    logic [7:0]  om;
    logic [15:0] flim;
    logic [15:0] rlim;
    logic [15:0] mtq;
    logic        tgt;
    logic        fe;
    logic [15:0] sw;
    int          mismatches = 0;
    int          checks_done = 0;

    always #50 clk_sys = ~clk_sys;

    // short ms prescale keeps the filter scenarios brief
    tls_core #(.CYC_MS(4)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .param_wr_en(wen),
        .param_wr_idx(widx), .param_wdata(wdat), .param_rd_idx(ridx),
        .param_rdata(rdat), .control_word(cw), .op_mode(om),
        .fwd_torque_limit_primary(fprim), .rev_torque_limit_primary(rprim),
        .max_torque_limit_one(lim1), .motor_max_torque(mmax),
        .travel_direction_select(dir),
        .torque_polarity_reflect_select(pol), .droop_count(droop),
        .following_error_level(fe_lvl), .position_error(perr),
        .in_position_range(prng), .speed_error(serr),
        .speed_reached_range(srng), .fwd_torque_limit(flim),
        .rev_torque_limit(rlim), .max_torque_report(mtq),
        .status_target_reached(tgt), .status_following_error(fe)
    );
    tls_ctrl_model ctrl (
        .clk_sys(clk_sys), .fwd_req(freq), .rev_req(rreq), .mode(mode),
        .tgt_bit(tgt), .fe_bit(fe), .control_word(cw), .op_mode(om),
        .status_word(sw)
    );

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checks_done++;
        if (seen !== ex) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, seen);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task wr(input logic [3:0] i, input logic [31:0] d);
        @(negedge clk_sys);
        wen = 1'b1;
        widx = i;
        wdat = d;
        @(negedge clk_sys);
        wen = 1'b0;
    endtask
    task rd(input logic [3:0] i, input logic [31:0] ex);
        @(negedge clk_sys);
        ridx = i;
        @(negedge clk_sys);
        chk("read data", rdat, ex);
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task t_reset;
        logic [3:0]  ix [8];
        logic [31:0] ev [8];
        ix = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hb};
        ev = '{32'h0, 32'h2710, 32'h2710, 32'h0, 32'h0, 32'h0, 32'h10, 32'h0};
        foreach (ix[k]) rd(ix[k], ev[k]);
        $display("reset values done");
    endtask
    task t_select;
        wr(4'h1, 32'h0300);
        wr(4'h2, 32'h0400);
        freq = 1'b1;
        rreq = 1'b1;
        step(2);
        chk("fwd limit", flim, 32'h0100);
        chk("rev limit", rlim, 32'h0200);
        wr(4'h0, 32'h1);
        step(2);
        chk("fwd limit", flim, 32'h0300);
        chk("rev limit", rlim, 32'h0400);
        rreq = 1'b0;
        step(2);
        chk("fwd limit", flim, 32'h0300);
        chk("rev limit", rlim, 32'h0200);
        wr(4'h1, 32'h0);
        step(2);
        chk("fwd limit", flim, 32'h0);
        wr(4'h1, 32'h2000);
        step(2);
        chk("fwd limit", flim, 32'h1000);
        wr(4'h1, 32'h2711);
        rd(4'h1, 32'h2000);
        $display("limit selection done");
    endtask
    task t_maxtq;
        lim1 = 16'h0250;
        step(2);
        chk("fwd limit", flim, 32'h0250);
        chk("max torque", mtq, 32'h0250);
        wr(4'h6, 32'h0);
        step(2);
        chk("max torque", mtq, 32'h1000);
        chk("fwd limit", flim, 32'h1000);
        rd(4'h9, 32'h1000);
        wr(4'h0, 32'h0);
        step(2);
        chk("fwd limit", flim, 32'h0100);
        chk("rev limit", rlim, 32'h0200);
        wr(4'h0, 32'h1);
        wr(4'h6, 32'h10);
        lim1 = 16'h2710;
        $display("maximum torque done");
    endtask
    task t_swap;
        wr(4'h1, 32'h0300);
        for (int k = 0; k < 4; k++) begin
            dir = k[0];
            pol = k[1];
            rd(4'h7, (k[0] ^ k[1]) ? 32'h0400 : 32'h0300);
            rd(4'h8, (k[0] ^ k[1]) ? 32'h0300 : 32'h0400);
        end
        $display("object swap done");
    endtask
    task t_follow;
        logic [7:0] md [3];
        md = '{tls_pkg::MODE_PP, tls_pkg::MODE_PT, tls_pkg::MODE_JG};
        mode = tls_pkg::MODE_CSP;
        wr(4'h3, 32'h3);
        droop = 32'hc8;
        step(6);
        chk("following error", fe, 32'h0);
        step(20);
        chk("status bit 13", sw[13], 32'h1);
        droop = 32'h32;
        step(2);
        chk("following error", fe, 32'h0);
        foreach (md[k]) begin
            mode = md[k];
            droop = 32'hc8;
            step(22);
            chk("status bit 13", sw[13], 32'h1);
            droop = 32'h32;
            step(2);
        end
        mode = tls_pkg::MODE_PV;
        droop = 32'hc8;
        step(30);
        chk("following error", fe, 32'h0);
        mode = tls_pkg::MODE_CSP;
        fe_lvl = tls_pkg::FE_LEVEL_OFF;
        droop = 32'hffff_ffff;
        step(30);
        chk("following error", fe, 32'h0);
        droop = 32'h0;
        $display("following error done");
    endtask
    task t_inpos;
        mode = tls_pkg::MODE_PP;
        perr = 32'h5;
        wr(4'h4, 32'h0);
        step(2);
        chk("target reached", tgt, 32'h1);
        perr = 32'h14;
        step(2);
        chk("target reached", tgt, 32'h0);
        wr(4'h4, 32'h2);
        perr = 32'h5;
        step(3);
        chk("target reached", tgt, 32'h0);
        step(14);
        chk("status bit 10", sw[10], 32'h1);
        mode = tls_pkg::MODE_CSP;
        step(20);
        chk("target reached", tgt, 32'h0);
        prng = 32'hffff_ffff;
        perr = 32'hffff_0000;
        step(2);
        chk("target reached", tgt, 32'h1);
        rd(4'ha, 32'h0000_0400);
        prng = 32'ha;
        $display("in-position done");
    endtask
    task t_speed;
        mode = tls_pkg::MODE_PV;
        wr(4'h5, 32'h2);
        serr = 32'h5;
        step(3);
        chk("target reached", tgt, 32'h0);
        step(14);
        chk("status bit 10", sw[10], 32'h1);
        serr = 32'h14;
        step(2);
        chk("target reached", tgt, 32'h0);
        mode = tls_pkg::MODE_PP;
        serr = 32'h5;
        step(20);
        chk("target reached", tgt, 32'h0);
        $display("speed reached done");
    endtask

    // the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        wrap_up;
    end
    initial begin
        step(3);
        rst_n = 1'b1;
        t_reset;
        t_select;
        t_maxtq;
        t_swap;
        t_follow;
        t_inpos;
        t_speed;
        wrap_up;
    end
endmodule
`default_nettype wire
